// File: rtl/pmcs_defines.vh
// constants for the power mode and clock switch block
`ifndef PMCS_DEFINES_VH
`define PMCS_DEFINES_VH

// clock select codes
`define PMCS_SEL_W          3
`define PMCS_SEL_RESERVED   3'h0
`define PMCS_SEL_SLOW       3'h7
`define PMCS_SEL_RESET      3'h2

// low power states
`define PMCS_LP_W           3
`define PMCS_LP_RUN         3'h0
`define PMCS_LP_SLEEP       3'h1
`define PMCS_LP_IDLE_STATE_ZERO       3'h2
`define PMCS_LP_IDLE_STATE_ONE       3'h3
`define PMCS_LP_IDLE_STATE_TWO       3'h4

// oscillator start-up times in nanoseconds, clock period in ns
`define PMCS_CLK_PERIOD_NS  5
`define PMCS_FAST_START_NS  1000
`define PMCS_SLOW_START_NS  2000
`define PMCS_FAST_START_CYC \
  ((`PMCS_FAST_START_NS + `PMCS_CLK_PERIOD_NS - 1) / `PMCS_CLK_PERIOD_NS)
`define PMCS_SLOW_START_CYC \
  ((`PMCS_SLOW_START_NS + `PMCS_CLK_PERIOD_NS - 1) / `PMCS_CLK_PERIOD_NS)

// oscillator enable reset value
`define PMCS_FAST_EN_RESET  1'b1

`endif

// File: rtl/pmcs_osc_ready.v
// oscillator start-up timer giving a stable flag
`timescale 1ns/10ps
`default_nettype none

module pmcs_osc_ready
#(
  parameter integer START_CYC = 200,
  parameter integer CNT_W     = 12
)
(
  // clock and reset
  input  wire             clk_sys_in,
  input  wire             sys_rst_in,
  // oscillator run request and stable flag
  input  wire             run_in,
  output reg              stable_out
);

  reg [CNT_W-1:0] count;

  // restart the count each time the oscillator is stopped
  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      count      <= {CNT_W{1'b0}};
      stable_out <= 1'b0;
    end
    else if (!run_in)
    begin
      count      <= {CNT_W{1'b0}};
      stable_out <= 1'b0;
    end
    else if (!stable_out)
    begin
      if (count == START_CYC[CNT_W-1:0] - 1'b1)
        stable_out <= 1'b1;
      count <= count + 1'b1;
    end
  end

endmodule // pmcs_osc_ready

`default_nettype wire

// File: rtl/pmcs_top.v
// power mode controller with system clock select and wake-up logic
`timescale 1ns/10ps
`default_nettype none
`include "pmcs_defines.vh"

// Notes on behaviour
// - fast/slow only by clock select; low power only by halt.
// - select code 111 runs the system clock from the slow sub clock.
// - switch to slow clock completes only once slow oscillator stable.
// - codes 001 to 110 divide fast clock by 2 up to 64.
// - fast restart after slow mode is shown by the stable flag.
// - enabling fast oscillator clears stable flag until it stabilises.
// - halt with both keeps low enters sleep; only watchdog runs.
// - halt with fast 0, slow 1 enters idle zero; sub clock runs.
// - halt with both keeps high enters idle one; both clocks run.
// - halt with fast 1, slow 0 enters idle two; fast runs only.
// - low power stops program at halt and keeps all state.
// - entering low power sets power-down flag, clears timeout flag.
// - entering low power clears watchdog counter, which keeps counting.
// - wake on enabled port A falling edge, interrupt, or watchdog.
// - power-down flag clears only on power-up or watchdog clear.
// - watchdog wake sets timeout, resets only program counter, stack.
// - port wake resumes at the instruction after the halt.
// - disabled or stack-full interrupt wake resumes after halt, pending.
// - enabled interrupt with stack room wakes into interrupt response.
// - interrupt already pending before halt cannot wake the device.
module pmcs_top
#(
  parameter integer PORT_W     = 8,
  parameter integer IRQ_W      = 8,
  parameter integer FAST_START = `PMCS_FAST_START_CYC,
  parameter integer SLOW_START = `PMCS_SLOW_START_CYC
)
(
  // clock and reset
  input  wire                   clk_sys_in,
  input  wire                   sys_rst_in,
  // clock configuration from the core
  input  wire [`PMCS_SEL_W-1:0] sys_clk_select_in,
  input  wire                   sys_clk_select_wr_in,
  input  wire                   fast_osc_idle_keep_in,
  input  wire                   slow_osc_idle_keep_in,
  input  wire                   fast_osc_enable_in,
  // core events
  input  wire                   halt_exec_in,
  input  wire                   clr_wdt_exec_in,
  input  wire                   irq_stack_full_in,
  // wake sources
  input  wire [PORT_W-1:0]      porta_pins_in,
  input  wire [PORT_W-1:0]      porta_wake_enable_in,
  input  wire [IRQ_W-1:0]       irq_req_in,
  input  wire [IRQ_W-1:0]       irq_enable_in,
  input  wire                   watchdog_overflow_in,
  // clock outputs
  output reg                    fast_osc_run_out,
  output reg                    slow_osc_run_out,
  output reg                    sub_clk_run_out,
  output reg  [`PMCS_SEL_W-1:0] sys_clk_select_out,
  output reg                    sys_clk_en_out,
  output wire                   fast_osc_stable_flag_out,
  output wire                   slow_osc_stable_out,
  // core control
  output reg                    cpu_run_out,
  output reg  [`PMCS_LP_W-1:0]  lp_state_out,
  output reg                    power_down_flag_out,
  output reg                    watchdog_timeout_flag_out,
  output reg                    watchdog_clear_out,
  output reg                    pc_sp_reset_out,
  output reg                    irq_service_out,
  output reg                    resume_next_out
);

  // divider of the fast oscillator set by the select code, one enable pulse per period
  function [6:0] pmcs_div_mask;
    input [`PMCS_SEL_W-1:0] sel;
    begin
      case (sel)
        3'h1:    pmcs_div_mask = 7'h01;
        3'h2:    pmcs_div_mask = 7'h03;
        3'h3:    pmcs_div_mask = 7'h07;
        3'h4:    pmcs_div_mask = 7'h0f;
        3'h5:    pmcs_div_mask = 7'h1f;
        3'h6:    pmcs_div_mask = 7'h3f;
        default: pmcs_div_mask = 7'h3f;
      endcase
    end
  endfunction

  // pick the idle state from the two keep bits
  function [`PMCS_LP_W-1:0] pmcs_lp_pick;
    input fast_keep;
    input slow_keep;
    begin
      case ({fast_keep, slow_keep})
        2'b00:   pmcs_lp_pick = `PMCS_LP_SLEEP;
        2'b01:   pmcs_lp_pick = `PMCS_LP_IDLE_STATE_ZERO;
        2'b11:   pmcs_lp_pick = `PMCS_LP_IDLE_STATE_ONE;
        2'b10:   pmcs_lp_pick = `PMCS_LP_IDLE_STATE_TWO;
        default: pmcs_lp_pick = `PMCS_LP_SLEEP;
      endcase
    end
  endfunction

  // controller states
  localparam [1:0] ST_RUN  = 2'h0;
  localparam [1:0] ST_LOW  = 2'h1;
  localparam [1:0] ST_WAKE = 2'h2;

  reg  [1:0]             state;
  reg  [`PMCS_SEL_W-1:0] pend_sel;
  reg  [PORT_W-1:0]      port_prev;
  reg  [IRQ_W-1:0]       irq_masked;
  reg  [6:0]             div_cnt;
  reg  [1:0]             wake_kind;
  wire                   fast_stable;
  wire                   slow_stable;
  wire                   sel_is_slow;
  wire                   port_wake;
  wire [IRQ_W-1:0]       irq_new;
  wire                   irq_wake;
  wire                   any_wake;
  wire                   sel_ready;

  localparam [1:0] WK_PORT = 2'h0;
  localparam [1:0] WK_IRQ  = 2'h1;
  localparam [1:0] WK_WDT  = 2'h2;

  // slow oscillator always runs for the watchdog; timer models its start
  pmcs_osc_ready #(.START_CYC(SLOW_START), .CNT_W(16)) u_slow_ready
  (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .run_in     (slow_osc_run_out),
    .stable_out (slow_stable)
  );

  // fast flag drops on every stop so a restart reads unstable first
  pmcs_osc_ready #(.START_CYC(FAST_START), .CNT_W(16)) u_fast_ready
  (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .run_in     (fast_osc_run_out),
    .stable_out (fast_stable)
  );

  assign fast_osc_stable_flag_out = fast_stable;
  assign slow_osc_stable_out      = slow_stable;
  assign sel_is_slow = (sys_clk_select_out == `PMCS_SEL_SLOW);
  assign sel_ready   = sel_is_slow ? slow_stable : fast_stable;

  // port falling edge on an enabled pin
  assign port_wake = |(port_prev & ~porta_pins_in & porta_wake_enable_in);
  // requests pending at halt are masked off from waking
  assign irq_new  = irq_req_in & ~irq_masked;
  assign irq_wake = |irq_new;
  assign any_wake = port_wake | irq_wake | watchdog_overflow_in;

  // port history for edge detection
  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      port_prev <= {PORT_W{1'b0}};
    else
      port_prev <= porta_pins_in;
  end

  // clock select register; pending slow switch waits for stability
  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sys_clk_select_out <= `PMCS_SEL_RESET;
      pend_sel           <= `PMCS_SEL_RESET;
    end
    else
    begin
      // the reserved code is ignored rather than trusted
      if (sys_clk_select_wr_in &&
          sys_clk_select_in != `PMCS_SEL_RESERVED)
        pend_sel <= sys_clk_select_in;
      if (pend_sel == `PMCS_SEL_SLOW)
      begin
        if (slow_stable)
          sys_clk_select_out <= pend_sel;
      end
      else
        sys_clk_select_out <= pend_sel;
    end
  end

  // system clock enable from the divider, held while cpu is off
  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      div_cnt        <= 7'h00;
      sys_clk_en_out <= 1'b0;
    end
    else if (!cpu_run_out)
    begin
      div_cnt        <= 7'h00;
      sys_clk_en_out <= 1'b0;
    end
    else if (sel_is_slow)
    begin
      // slow mode: the sub clock itself paces the core outside this block
      div_cnt        <= 7'h00;
      sys_clk_en_out <= 1'b1;
    end
    else if (div_cnt >= pmcs_div_mask(sys_clk_select_out))
    begin
      div_cnt        <= 7'h00;
      sys_clk_en_out <= fast_stable;
    end
    else
    begin
      div_cnt        <= div_cnt + 7'h01;
      sys_clk_en_out <= 1'b0;
    end
  end

  // oscillator run requests from mode and keep bits
  always @*
  begin
    slow_osc_run_out = 1'b1;
    fast_osc_run_out = fast_osc_enable_in | ~sel_is_slow;
    sub_clk_run_out  = 1'b1;
    if (state == ST_LOW)
    begin
      case (lp_state_out)
        `PMCS_LP_SLEEP:
        begin
          fast_osc_run_out = 1'b0;
          sub_clk_run_out  = 1'b0;
        end
        `PMCS_LP_IDLE_STATE_ZERO:
          fast_osc_run_out = 1'b0;
        `PMCS_LP_IDLE_STATE_ONE:
          fast_osc_run_out = 1'b1;
        `PMCS_LP_IDLE_STATE_TWO:
        begin
          fast_osc_run_out = 1'b1;
          sub_clk_run_out  = 1'b0;
        end
        default:
          fast_osc_run_out = 1'b0;
      endcase
    end
  end

  // halt, low power and wake sequencing
  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state                     <= ST_RUN;
      lp_state_out              <= `PMCS_LP_RUN;
      cpu_run_out               <= 1'b1;
      irq_masked                <= {IRQ_W{1'b0}};
      wake_kind                 <= WK_PORT;
      power_down_flag_out       <= 1'b0;
      watchdog_timeout_flag_out <= 1'b0;
      watchdog_clear_out        <= 1'b0;
      pc_sp_reset_out           <= 1'b0;
      irq_service_out           <= 1'b0;
      resume_next_out           <= 1'b0;
    end
    else
    begin
      watchdog_clear_out <= 1'b0;
      pc_sp_reset_out    <= 1'b0;
      irq_service_out    <= 1'b0;
      resume_next_out    <= 1'b0;
      if (clr_wdt_exec_in && !(state == ST_RUN && halt_exec_in))
        power_down_flag_out <= 1'b0;
      case (state)
        ST_RUN:
          if (halt_exec_in)
          begin
            state        <= ST_LOW;
            lp_state_out <= pmcs_lp_pick(fast_osc_idle_keep_in,
                                         slow_osc_idle_keep_in);
            cpu_run_out  <= 1'b0;
            irq_masked   <= irq_req_in;
            power_down_flag_out       <= 1'b1;
            watchdog_timeout_flag_out <= 1'b0;
            watchdog_clear_out        <= 1'b1;
          end
        ST_LOW:
          if (any_wake)
          begin
            state        <= ST_WAKE;
            lp_state_out <= `PMCS_LP_RUN;
            // watchdog wins so its pc reset is never lost
            if (watchdog_overflow_in)
            begin
              wake_kind                 <= WK_WDT;
              watchdog_timeout_flag_out <= 1'b1;
            end
            else if (irq_wake)
              wake_kind <= WK_IRQ;
            else
              wake_kind <= WK_PORT;
          end
        ST_WAKE:
          if (sel_ready)
          begin
            state       <= ST_RUN;
            cpu_run_out <= 1'b1;
            irq_masked  <= {IRQ_W{1'b0}};
            case (wake_kind)
              WK_WDT:
                pc_sp_reset_out <= 1'b1;
              WK_IRQ:
                if ((|(irq_new & irq_enable_in)) && !irq_stack_full_in)
                  irq_service_out <= 1'b1;
                else
                  resume_next_out <= 1'b1;
              default:
                resume_next_out <= 1'b1;
            endcase
          end
        default:
          state <= ST_RUN;
      endcase
    end
  end

endmodule // pmcs_top

`default_nettype wire

// File: test/pmcs_asserts.sv
// concurrent checks on the power mode and clock switch ports
`timescale 1ns/10ps
`default_nettype none
`include "pmcs_defines.vh"
module pmcs_asserts
(
  // clock and reset
  input wire logic       clk_sys_in,
  input wire logic       sys_rst_in,
  // core requests
  input wire logic [2:0] sys_clk_select_in,
  input wire logic       sys_clk_select_wr_in,
  input wire logic       fast_osc_idle_keep_in,
  input wire logic       slow_osc_idle_keep_in,
  input wire logic       halt_exec_in,
  input wire logic       clr_wdt_exec_in,
  input wire logic       watchdog_overflow_in,
  // clock side
  input wire logic       fast_osc_run_out,
  input wire logic       slow_osc_run_out,
  input wire logic       sub_clk_run_out,
  input wire logic [2:0] sys_clk_select_out,
  input wire logic       sys_clk_en_out,
  input wire logic       fast_osc_stable_flag_out,
  input wire logic       slow_osc_stable_out,
  // core side
  input wire logic       cpu_run_out,
  input wire logic [2:0] lp_state_out,
  input wire logic       power_down_flag_out,
  input wire logic       watchdog_timeout_flag_out,
  input wire logic       watchdog_clear_out,
  input wire logic       pc_sp_reset_out,
  input wire logic       irq_service_out,
  input wire logic       resume_next_out
);
  default clocking dc @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  // halt counts only from a fully running core
  wire       halt_ok = halt_exec_in && cpu_run_out && lp_state_out == 3'h0;
  wire [2:0] lp_pick = fast_osc_idle_keep_in ?
    (slow_osc_idle_keep_in ? `PMCS_LP_IDLE_STATE_ONE : `PMCS_LP_IDLE_STATE_TWO) :
    (slow_osc_idle_keep_in ? `PMCS_LP_IDLE_STATE_ZERO : `PMCS_LP_SLEEP);
  wire       in_lp   = lp_state_out != `PMCS_LP_RUN;

  halt_flags_a: assert property (halt_ok |=> !cpu_run_out &&
    power_down_flag_out && !watchdog_timeout_flag_out && watchdog_clear_out)
    else $error("halt entry flags wrong");
  lp_map_a: assert property (
    halt_ok |=> lp_state_out == $past(lp_pick))
    else $error("low power state does not follow keep bits");
  lp_clocks_a: assert property (in_lp |->
    sub_clk_run_out == (lp_state_out inside {3'h2, 3'h3}) &&
    fast_osc_run_out == (lp_state_out inside {3'h3, 3'h4}))
    else $error("clock gating wrong in low power");
  wdog_osc_a: assert property (slow_osc_run_out)
    else $error("slow oscillator stopped");
  wdt_wake_a: assert property (
    in_lp && watchdog_overflow_in |=>
    lp_state_out == 3'h0 && watchdog_timeout_flag_out)
    else $error("watchdog wake missing");
  pdf_clear_a: assert property ($fell(power_down_flag_out) |->
    $past(clr_wdt_exec_in)) else $error("power-down flag cleared alone");
  sel_fast_a: assert property (sys_clk_select_wr_in &&
    sys_clk_select_in inside {[1:6]} |-> ##2
    sys_clk_select_out == $past(sys_clk_select_in, 2))
    else $error("divider select not applied");
  sel_slow_a: assert property ($rose(sys_clk_select_out == 3'h7) |->
    slow_osc_stable_out) else $error("slow switch before stable");
  wake_end_a: assert property ($rose(cpu_run_out) |->
    $onehot({pc_sp_reset_out, irq_service_out, resume_next_out}) &&
    (sys_clk_select_out == 3'h7 ? slow_osc_stable_out :
     fast_osc_stable_flag_out)) else $error("resume before stable");
  stopped_a: assert property (
    !cpu_run_out && !$past(cpu_run_out) |-> !sys_clk_en_out)
    else $error("system clock runs while halted");
endmodule // pmcs_asserts

bind pmcs_top pmcs_asserts u_chk (.clk_sys_in, .sys_rst_in,
  .sys_clk_select_in, .sys_clk_select_wr_in, .fast_osc_idle_keep_in,
  .slow_osc_idle_keep_in, .halt_exec_in, .clr_wdt_exec_in,
  .watchdog_overflow_in, .fast_osc_run_out, .slow_osc_run_out,
  .sub_clk_run_out, .sys_clk_select_out, .sys_clk_en_out,
  .fast_osc_stable_flag_out, .slow_osc_stable_out, .cpu_run_out,
  .lp_state_out, .power_down_flag_out, .watchdog_timeout_flag_out,
  .watchdog_clear_out, .pc_sp_reset_out, .irq_service_out,
  .resume_next_out);
`default_nettype wire

// File: test/pmcs_core_model.sv
// processor core model issuing select writes, halts and watchdog clears
`timescale 1ns/10ps
`default_nettype none
module pmcs_core_model
(
  // clock and block status
  input  wire logic       clk_sys_in,
  input  wire logic       cpu_run_in,
  input  wire logic       fast_stable_in,
  // instruction side effects
  output var  logic [2:0] sel_out,
  output var  logic       sel_wr_out,
  output var  logic       halt_out,
  output var  logic       clr_wdt_out
);
  initial {sel_out, sel_wr_out, halt_out, clr_wdt_out} = 6'h10;

  // one instruction slot; a stopped core issues nothing
  task automatic issue(input logic [2:0] code, input logic wr, hlt, clr);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    while ((!cpu_run_in || (wr && code != 3'h7 && !fast_stable_in))
           && n < 1000);
    if (code == 3'h0)
      wr = 1'b0;
    {sel_out, sel_wr_out, halt_out, clr_wdt_out} = {code, wr, hlt, clr};
    @(posedge clk_sys_in);
    #1;
    {sel_wr_out, halt_out, clr_wdt_out} = 3'h0;
  endtask
endmodule // pmcs_core_model
`default_nettype wire

// File: test/testbench.sv
// self-checking bench for the power mode and clock switch block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic       clk_sys_in, sys_rst_in, fk, sk, f_en, full, wdt;
  logic [7:0] pins, wake_en, irq_req, irq_en;
  logic [2:0] sel, sel_q, lp;
  logic       wr, halt, clr, f_run, s_run, sub_run, clk_en, f_stb, s_stb;
  logic       cpu_run, power_down_flag, tof, wclr, pcsp, isvc, rnext;
  int         error_cnt, n_checks, seed, k, n, b;
  int         exp_q[$];

  // short start-up counts keep the run brief
  pmcs_top #(.FAST_START(4), .SLOW_START(4)) uut (.clk_sys_in, .sys_rst_in,
    .sys_clk_select_in(sel), .sys_clk_select_wr_in(wr),
    .fast_osc_idle_keep_in(fk), .slow_osc_idle_keep_in(sk),
    .fast_osc_enable_in(f_en), .halt_exec_in(halt), .clr_wdt_exec_in(clr),
    .irq_stack_full_in(full), .porta_pins_in(pins),
    .porta_wake_enable_in(wake_en), .irq_req_in(irq_req),
    .irq_enable_in(irq_en), .watchdog_overflow_in(wdt),
    .fast_osc_run_out(f_run), .slow_osc_run_out(s_run),
    .sub_clk_run_out(sub_run), .sys_clk_select_out(sel_q),
    .sys_clk_en_out(clk_en), .fast_osc_stable_flag_out(f_stb),
    .slow_osc_stable_out(s_stb), .cpu_run_out(cpu_run), .lp_state_out(lp),
    .power_down_flag_out(power_down_flag), .watchdog_timeout_flag_out(tof),
    .watchdog_clear_out(wclr), .pc_sp_reset_out(pcsp),
    .irq_service_out(isvc), .resume_next_out(rnext));
  pmcs_core_model u_core (.clk_sys_in, .cpu_run_in(cpu_run),
    .fast_stable_in(f_stb), .sel_out(sel), .sel_wr_out(wr),
    .halt_out(halt), .clr_wdt_out(clr));

  task automatic chk(input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // every input change lands 1 ns after a rising edge
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys_in);
    #1;
  endtask
  // reference state for a halt with keep bits m[1] fast, m[0] slow
  function automatic logic [2:0] exp_lp(input int m);
    case (m & 3)
      0: return 3'h1;
      1: return 3'h2;
      3: return 3'h3;
      default: return 3'h4;
    endcase
  endfunction

  initial
  begin
    clk_sys_in = 0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // hang guard, far beyond the few hundred cycles needed
  initial
  begin
    #100000;
    error_cnt++;
    end_sim;
  end

  initial
  begin
    {fk, sk, full, wdt, wake_en, irq_req, irq_en} = 0;
    f_en = 1;
    pins = 8'hff;
    seed = 18;
    sys_rst_in = 1;
    tick(6);
    sys_rst_in = 0;
    chk({cpu_run, power_down_flag, tof, lp}, 8'h20);
    $display("reset test done");
    // slow mode, fast oscillator off and restarted
    u_core.issue(3'h7, 1, 0, 0);
    n = 0;
    while (sel_q !== 3'h7 && n < 50)
    begin
      tick(1);
      n++;
    end
    tick(1);
    chk({sel_q, s_stb, clk_en}, 8'h1f);
    f_en = 0;
    tick(3);
    chk({f_run, f_stb}, 8'h0);
    f_en = 1;
    tick(1);
    chk(f_stb, 8'h0);
    n = 0;
    while (f_stb !== 1'b1 && n < 20)
    begin
      tick(1);
      n++;
    end
    chk(f_stb, 8'h1);
    $display("slow test done");
    // every divider code and its enable spacing
    for (k = 1; k < 7; k++)
    begin
      u_core.issue(k[2:0], 1, 0, 0);
      tick(2);
      chk(sel_q, k[7:0]);
      n = 0;
      while (clk_en !== 1'b1 && n < 200)
      begin
        tick(1);
        n++;
      end
      n = 0;
      do
      begin
        tick(1);
        n++;
      end
      while (clk_en !== 1'b1 && n < 200);
      chk(n[7:0], 8'h1 << k);
    end
    $display("divider test done");
    // all keep settings and wake sources; bit 0 pends before each halt
    irq_req = 8'h01;
    for (k = 0; k < 8; k++)
    begin
      {fk, sk} = k[1:0];
      irq_en = {6'h0, k > 3, 1'b0};
      full = (k == 7);
      u_core.issue(sel_q, 0, 1, 0);
      chk({cpu_run, power_down_flag, tof, wclr}, 8'h5);
      chk(lp, exp_lp(k));
      // watchdog clock always on; fast follows fast keep, sub follows slow
      chk({s_run, f_run, sub_run}, {1'b1, k[1:0]});
      tick(5);
      chk(lp, exp_lp(k));
      case (k % 3)
        0:
        begin
          b = $unsigned($random(seed)) % 8;
          wake_en = 8'h1 << b;
          pins[b] = 1'b0;
          exp_q.push_back(1);
        end
        1:
        begin
          irq_req[1] = 1'b1;
          exp_q.push_back((irq_en[1] && !full) ? 2 : 1);
        end
        default:
        begin
          wdt = 1'b1;
          exp_q.push_back(4);
        end
      endcase
      tick(1);
      wdt = 1'b0;
      n = 0;
      while (cpu_run !== 1'b1 && n < 100)
      begin
        tick(1);
        n++;
      end
      chk({pcsp, isvc, rnext},
        exp_q.pop_front());
      chk({power_down_flag, tof}, {1'b1, k % 3 == 2});
      pins = 8'hff;
      irq_req = 8'h01;
      wake_en = 0;
      u_core.issue(sel_q, 0, 0, 1);
      chk(power_down_flag, 8'h0);
    end
    $display("halt and wake test done");
    end_sim;
  end
endmodule // testbench
`default_nettype wire
